// File: jtd_tap_top.v
// test access port with eight bit instruction register and one dummy cell
// assumes tck well below clk_sys/4; all port pins are sampled on clk_sys
`timescale 1ns/100ps
`include "jtd_defines.vh"
module jtd_tap_top (
	input wire clk_sys,
	input wire rst,
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire trst_n,
	output reg tdo,
	output reg tdo_en,
	output reg [7:0] instr_active,
	input wire [1:0] emu_pull_req,
	input wire [1:0] emulation_control_line_in,
	output reg [1:0] emulation_control_line_out,
	output reg [1:0] emulation_control_line_oe,
	output reg [1:0] emulation_control_line_level
);
	localparam ST_RESET = 4'd0;
	localparam ST_IDLE = 4'd1;
	localparam ST_SEL_DR = 4'd2;
	localparam ST_CAP_DR = 4'd3;
	localparam ST_SHIFT_DR = 4'd4;
	localparam ST_EXIT1_DR = 4'd5;
	localparam ST_PAUSE_DR = 4'd6;
	localparam ST_EXIT2_DR = 4'd7;
	localparam ST_UPD_DR = 4'd8;
	localparam ST_SEL_IR = 4'd9;
	localparam ST_CAP_IR = 4'd10;
	localparam ST_SHIFT_IR = 4'd11;
	localparam ST_EXIT1_IR = 4'd12;
	localparam ST_PAUSE_IR = 4'd13;
	localparam ST_EXIT2_IR = 4'd14;
	localparam ST_UPD_IR = 4'd15;

	wire tck_s;
	wire tms_s;
	wire tdi_s;
	wire trst_n_s;
	wire [1:0] emu_in_s;
	reg tck_d_reg;
	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [7:0] ir_shift_reg;
	reg bypass_reg;
	reg bnd_shift_reg;
	reg bnd_upd_reg;
	reg sel_bnd;
	reg dr_bit;
	wire tck_rise;
	wire tck_fall;

	// pins cross into clk_sys before any logic looks at them
	jtd_sync u_sync_tck (.clk_sys(clk_sys), .rst(rst), .async_in(tck),
		.sync_out(tck_s));
	jtd_sync u_sync_tms (.clk_sys(clk_sys), .rst(rst), .async_in(tms),
		.sync_out(tms_s));
	jtd_sync u_sync_tdi (.clk_sys(clk_sys), .rst(rst), .async_in(tdi),
		.sync_out(tdi_s));
	jtd_sync u_sync_trst (.clk_sys(clk_sys), .rst(rst), .async_in(trst_n),
		.sync_out(trst_n_s));

	// tck edges found from the synchronised copy only
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tck_d_reg <= 1'b0;
		end else begin
			tck_d_reg <= tck_s;
		end
	end
	assign tck_rise = tck_s & ~tck_d_reg;
	assign tck_fall = ~tck_s & tck_d_reg;

	// standard tap sequence driven by tms on each rising tck
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_RESET: state_next = tms_s ? ST_RESET : ST_IDLE;
		ST_IDLE: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
		ST_SEL_DR: state_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
		ST_CAP_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
		ST_SHIFT_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
		ST_EXIT1_DR: state_next = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
		ST_PAUSE_DR: state_next = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
		ST_EXIT2_DR: state_next = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
		ST_UPD_DR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
		ST_SEL_IR: state_next = tms_s ? ST_RESET : ST_CAP_IR;
		ST_CAP_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
		ST_SHIFT_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
		ST_EXIT1_IR: state_next = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
		ST_PAUSE_IR: state_next = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
		ST_EXIT2_IR: state_next = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
		ST_UPD_IR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
		default: state_next = ST_RESET;
		endcase
	end

	// external test, sample and high impedance all pick the dummy cell;
	// bypass, private and unknown codes pick bypass, the safe path
	always @* begin
		sel_bnd = 1'b0;
		case (instr_active)
		`JTD_IR_EXTEST: sel_bnd = 1'b1;
		`JTD_IR_SAMPLE: sel_bnd = 1'b1;
		`JTD_IR_HIGHZ: sel_bnd = 1'b1;
		default: sel_bnd = 1'b0;
		endcase
		dr_bit = sel_bnd ? bnd_shift_reg : bypass_reg;
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= ST_RESET;
		end else if (!trst_n_s) begin
			state_reg <= ST_RESET;
		end else if (tck_rise) begin
			state_reg <= state_next;
		end
	end

	// instruction path: capture fixed pattern, shift lsb first, update
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ir_shift_reg <= `JTD_IR_RESET;
			instr_active <= `JTD_IR_RESET;
		end else if (!trst_n_s || state_reg == ST_RESET) begin
			ir_shift_reg <= `JTD_IR_RESET;
			instr_active <= `JTD_IR_RESET;
		end else if (tck_rise) begin
			case (state_reg)
			ST_CAP_IR: ir_shift_reg <= `JTD_IR_CAPTURE;
			ST_SHIFT_IR: ir_shift_reg <= {tdi_s, ir_shift_reg[7:1]};
			ST_UPD_IR: instr_active <= ir_shift_reg;
			default: ir_shift_reg <= ir_shift_reg;
			endcase
		end
	end

	// data path: one bypass bit and one dummy boundary cell
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bypass_reg <= 1'b0;
			bnd_shift_reg <= 1'b0;
			bnd_upd_reg <= 1'b0;
		end else if (!trst_n_s) begin
			bypass_reg <= 1'b0;
			bnd_shift_reg <= 1'b0;
			bnd_upd_reg <= 1'b0;
		end else if (tck_rise) begin
			case (state_reg)
			ST_CAP_DR: begin
				bypass_reg <= 1'b0;
				// capture the update stage so a loop-back reads back
				if (sel_bnd) begin
					bnd_shift_reg <= bnd_upd_reg;
				end
			end
			ST_SHIFT_DR: begin
				if (sel_bnd) begin
					bnd_shift_reg <= tdi_s;
				end else begin
					bypass_reg <= tdi_s;
				end
			end
			ST_UPD_DR: begin
				// update touches only the dummy cell, never any pin
				if (sel_bnd) begin
					bnd_upd_reg <= bnd_shift_reg;
				end
			end
			default: bypass_reg <= bypass_reg;
			endcase
		end
	end

	// tdo changes on falling tck so the next device samples it on rising
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tdo <= 1'b0;
			tdo_en <= 1'b0;
		end else if (!trst_n_s) begin
			tdo <= 1'b0;
			tdo_en <= 1'b0;
		end else if (tck_fall) begin
			if (state_reg == ST_SHIFT_IR) begin
				tdo <= ir_shift_reg[0];
				tdo_en <= 1'b1;
			end else if (state_reg == ST_SHIFT_DR) begin
				tdo <= dr_bit;
				tdo_en <= 1'b1;
			end else begin
				tdo_en <= 1'b0;
			end
		end
	end

	// emulation lines: drive low only; release lets the pull-up win
	genvar gi;
	generate
		for (gi = 0; gi < `JTD_EMU_LINES; gi = gi + 1) begin : g_emu
			jtd_sync u_sync_emu (.clk_sys(clk_sys), .rst(rst),
				.async_in(emulation_control_line_in[gi]),
				.sync_out(emu_in_s[gi]));
		end
	endgenerate

	// one process owns each vector so no bit has a second driver
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			emulation_control_line_out <= 2'h0;
			emulation_control_line_oe <= 2'h0;
			emulation_control_line_level <= 2'h3;
		end else begin
			emulation_control_line_out <= 2'h0;
			emulation_control_line_oe <= emu_pull_req;
			emulation_control_line_level <= emu_in_s;
		end
	end
endmodule

// File: jtd_defines.vh
// constants for the emulation test access port with one dummy boundary cell
// assumes inclusion by jtd_tap_top.v only; no process lives here
`ifndef JTD_DEFINES_VH
`define JTD_DEFINES_VH

`define JTD_IR_WIDTH 8
`define JTD_IR_EXTEST 8'h00
`define JTD_IR_SAMPLE 8'h02
`define JTD_IR_PRIV1 8'h03
`define JTD_IR_HIGHZ 8'h06
`define JTD_IR_BYPASS 8'hff
`define JTD_IR_PRIV_BASE 8'h20
`define JTD_IR_PRIV_LAST 8'h29
`define JTD_IR_CAPTURE 8'h01
`define JTD_IR_RESET 8'hff
`define JTD_EMU_LINES 2
`define JTD_SYNC_RESET 1'b0

`endif

// File: jtd_sync.v
// two-flop synchroniser for one level from outside the clk_sys domain
// assumes the level is stable for several clk_sys periods
`timescale 1ns/100ps
module jtd_sync (
	input wire clk_sys,
	input wire rst,
	input wire async_in,
	output reg sync_out
);
	reg meta_reg;

	// first stage feeds only the second stage
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// File: jtd_tap_checker.sv
// port checks for the emulation test access port
// assumes tck is a slow pin sampled on clk_sys; lines pulled up outside
`timescale 1ns/100ps
module jtd_tap_checker (
	input wire clk_sys,
	input wire rst,
	input wire tck,
	input wire trst_n,
	input wire tdo,
	input wire tdo_en,
	input wire [7:0] instr_active,
	input wire [1:0] emu_pull_req,
	input wire [1:0] emulation_control_line_in,
	input wire [1:0] emulation_control_line_out,
	input wire [1:0] emulation_control_line_oe,
	input wire [1:0] emulation_control_line_level
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	oe_follow_a: assert property (
		emulation_control_line_oe == $past(emu_pull_req))
		else $error("pull enable not one cycle after request");
	oe_hold_a: assert property (
		emu_pull_req[1] [*2] |-> emulation_control_line_oe[1])
		else $error("pull enable dropped during request");
	out_low_a: assert property (
		emulation_control_line_out == 2'h0)
		else $error("emulation line driven high");
	// window skips the flops refilling after reset
	level_track_a: assert property (
		!$past(rst, 4) &&
		emulation_control_line_in == $past(emulation_control_line_in) &&
		emulation_control_line_in == $past(emulation_control_line_in, 3)
		|-> emulation_control_line_level == emulation_control_line_in)
		else $error("line level not tracking pin");
	trst_bypass_a: assert property (
		(!trst_n) [*7] |-> instr_active == 8'hff && !tdo_en)
		else $error("test reset did not give bypass");
	ir_quiet_a: assert property (
		$changed(instr_active) |-> !tdo_en)
		else $error("instruction changed while shifting");
	tdo_fall_a: assert property (
		$changed(tdo) |-> !$past(tck, 2))
		else $error("serial out moved away from falling tck");
	en_fall_a: assert property (
		$changed(tdo_en) |-> !$past(tck, 2))
		else $error("out enable moved away from falling tck");
endmodule
bind jtd_tap_top jtd_tap_checker chk (.clk_sys(clk_sys), .rst(rst),
	.tck(tck), .trst_n(trst_n), .tdo(tdo), .tdo_en(tdo_en),
	.instr_active(instr_active), .emu_pull_req(emu_pull_req),
	.emulation_control_line_in(emulation_control_line_in),
	.emulation_control_line_out(emulation_control_line_out),
	.emulation_control_line_oe(emulation_control_line_oe),
	.emulation_control_line_level(emulation_control_line_level));

// File: jtd_ctrl_model.sv
// behavioural test controller driving the tap pins
// assumes clk_sys from the bench; tck stands low outside scans
`timescale 1ns/100ps
module jtd_ctrl_model (
	input wire clk_sys,
	input wire tdo,
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n
);
	logic [7:0] got;
	logic d;
	event done;
	initial begin
		tck = 0;
		tms = 1;
		tdi = 0;
		trst_n = 1;
	end
	// sample before the fall: the next bit only lands clocks later
	task automatic step(input logic ms, input logic di);
		tms = ms;
		tdi = di;
		repeat (4) @(negedge clk_sys);
		tck = 1;
		repeat (4) @(negedge clk_sys);
		d = tdo;
		tck = 0;
	endtask
	// data in toggles outside shifts so stale bits never look valid
	task automatic scan(input logic ir, input logic [7:0] v);
		step(1, ~tdi);
		if (ir) begin
			step(1, ~tdi);
		end
		step(0, ~tdi);
		step(0, ~tdi);
		for (int i = 0; i < 8; i++) begin
			step(i == 7, v[i]);
			got[i] = d;
		end
		step(1, ~tdi);
		step(0, ~tdi);
		-> done;
	endtask
	task automatic tms_reset();
		repeat (5) step(1, ~tdi);
		step(0, ~tdi);
	endtask
	task automatic pin_reset();
		trst_n = 0;
		repeat (10) @(negedge clk_sys);
		trst_n = 1;
		repeat (6) @(negedge clk_sys);
		// test reset parks the port in reset; scans start from idle
		step(0, ~tdi);
	endtask
endmodule

// File: jtag_emulation_tap_dummy_scan_tb_top.sv
// self-checking bench for jtd_tap_top with a controller model
// assumes the model owns all tap pins; emulation lines have pull-ups
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	fail_count++; $display("unexpected t=%0t got=%h exp=%h", $time, g, e); \
	end end
module jtag_emulation_tap_dummy_scan_tb_top;
	logic clk_sys = 0;
	logic rst = 1;
	logic [1:0] emu_pull_req = 2'h0;
	logic [7:0] c, v;
	logic [15:0] e;
	logic [15:0] exp_q[$];
	logic dp = 0;
	logic sel;
	// private codes loaded only to see them fall back to bypass
	logic [7:0] codes [0:6] = '{8'h00, 8'h02, 8'h06, 8'hff, 8'h03, 8'h20, 8'h29};
	integer seed = 32'ha4df;
	integer fail_count = 0;
	integer samples_checked = 0;
	integer cyc = 0;
	wire tck, tms, tdi, trst_n, tdo, tdo_en;
	// a released serial out reads as pulled up at the controller
	wire tdo_line = tdo_en ? tdo : 1'b1;
	wire [7:0] instr_active;
	wire [1:0] eout, eoe, elvl;
	wire [1:0] ein = ~eoe; // pulled up, only the block pulls low
	jtd_tap_top dut (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms),
		.tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_en(tdo_en),
		.instr_active(instr_active), .emu_pull_req(emu_pull_req),
		.emulation_control_line_in(ein), .emulation_control_line_out(eout),
		.emulation_control_line_oe(eoe), .emulation_control_line_level(elvl));
	jtd_ctrl_model m (.clk_sys(clk_sys), .tdo(tdo_line), .tck(tck), .tms(tms),
		.tdi(tdi), .trst_n(trst_n));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) begin
		if (!rst) emu_pull_req <= 2'($random(seed));
	end
	task automatic run(input logic ir, input logic [7:0] vi, et, ei);
		exp_q.push_back({ei, et});
		m.scan(ir, vi);
	endtask
	always @(m.done) begin
		e = exp_q.pop_front();
		`CHK(m.got, e[7:0])
		`CHK(instr_active, e[15:8])
	end
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 10000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys) rst = 0;
		repeat (6) @(negedge clk_sys);
		// the port leaves reset in test-logic-reset; walk it to idle
		m.tms_reset();
		foreach (codes[k]) begin
			c = codes[k];
			sel = c == 8'h00 || c == 8'h02 || c == 8'h06;
			run(1, c, 8'h01, c);
			repeat (2) begin
				v = 8'($random(seed));
				run(0, v, {v[6:0], sel ? dp : 1'b0}, c);
				if (sel) dp = v[7];
			end
			$display("code %h done", c);
		end
		run(1, 8'h06, 8'h01, 8'h06);
		run(0, 8'hff, {7'h7f, dp}, 8'h06);
		dp = 1'b1;
		m.pin_reset();
		dp = 1'b0;
		v = 8'($random(seed));
		run(0, v, {v[6:0], 1'b0}, 8'hff);
		run(1, 8'h00, 8'h01, 8'h00);
		v = 8'($random(seed));
		run(0, v, {v[6:0], dp}, 8'h00);
		m.tms_reset();
		`CHK(instr_active, 8'hff)
		$display("reset tests done");
		wrap_up();
	end
endmodule
